// ### src/amc_clkdiv.sv
// Internal state-machine tick and conversion tick generator.
// Assumes mclk_i is an asynchronous pin well below half of ref_clk_i.
`timescale 1ns/100ps
`default_nettype none
module amc_clkdiv
  import amc_pkg::*;
#(
  parameter logic [7:0] DIRECT17_DIV = 8'h0A
) (
  input  wire logic ref_clk_i,
  input  wire logic nrst_i,
  input  wire logic mclk_i,
  amc_if.clk_gen    cif
);
  logic        m1_r, m2_r, m3_r;
  logic [16:0] osc_acc_r, osc_acc_nxt;
  logic [16:0] der_acc_r, der_acc_nxt;
  logic [2:0]  div_cnt_r, div_cnt_nxt;
  logic        int_r, int_nxt, conv_r, conv_nxt;
  logic        mclk_edge;
  logic [4:0]  mult;
  logic [16:0] num, den, osc_sum, der_sum;
  logic [2:0]  div_last;

  assign mclk_edge = m2_r & ~m3_r;
  assign cif.int_tick  = int_r;
  assign cif.conv_tick = conv_r;

  always_comb begin
    mult = cif.ratio_sel ? MULT_SEL1 : MULT_SEL0;
    num  = cif.pll_en ? 17'(cif.pll_k * mult) : 17'(mult);
    if (cif.pll_en) begin
      den = 17'(cif.pll_p * (cif.ratio_sel ? PDIV_SEL1 : PDIV_SEL0)); // RQ12
    end else begin
      den = 17'(cif.pll_q * (cif.ratio_sel ? DIRECT17_DIV : QDIV_SEL0)); // RQ12 RQ13
    end
    if (den == 17'h0) begin
      den = 17'h1;
    end
    osc_sum     = osc_acc_r + 17'(INT_CLK_KHZ);
    der_sum     = der_acc_r + num;
    osc_acc_nxt = osc_acc_r;
    der_acc_nxt = der_acc_r;
    int_nxt     = 1'b0;
    if (!cif.use_audio) begin // RQ11
      if (osc_sum >= 17'(REF_CLK_KHZ)) begin
        osc_acc_nxt = osc_sum - 17'(REF_CLK_KHZ);
        int_nxt     = 1'b1;
      end else begin
        osc_acc_nxt = osc_sum;
      end
    end else if (mclk_edge) begin // RQ11
      if (der_sum >= den) begin
        der_acc_nxt = der_sum - den;
        int_nxt     = 1'b1;
      end else begin
        der_acc_nxt = der_sum;
      end
    end
    div_last    = 3'((4'h1 << cif.div_sel) - 4'h1);
    div_cnt_nxt = div_cnt_r;
    conv_nxt    = 1'b0;
    if (int_nxt) begin // RQ8
      if (div_cnt_r >= div_last) begin
        div_cnt_nxt = 3'h0;
        conv_nxt    = 1'b1;
      end else begin
        div_cnt_nxt = div_cnt_r + 3'h1;
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      m1_r      <= 1'b0;
      m2_r      <= 1'b0;
      m3_r      <= 1'b0;
      osc_acc_r <= 17'h0;
      der_acc_r <= 17'h0;
      div_cnt_r <= 3'h0;
      int_r     <= 1'b0;
      conv_r    <= 1'b0;
    end else begin
      m1_r      <= mclk_i;
      m2_r      <= m1_r;
      m3_r      <= m2_r;
      osc_acc_r <= osc_acc_nxt;
      der_acc_r <= der_acc_nxt;
      div_cnt_r <= div_cnt_nxt;
      int_r     <= int_nxt;
      conv_r    <= conv_nxt;
    end
  end

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);

  property p_conv_on_int;
    conv_r |-> int_r;
  endproperty
  a_conv_on_int: assert property (p_conv_on_int) else $error("conv tick without int tick"); // RQ8

  property p_audio_tick;
    (cif.use_audio && $past(cif.use_audio)) ##0 int_r |-> $past(mclk_edge);
  endproperty
  a_audio_tick: assert property (p_audio_tick) else $error("audio tick without mclk edge"); // RQ11

  property p_osc_rate;
    (!cif.use_audio && $past(!cif.use_audio) && int_r) |=> !int_r;
  endproperty
  a_osc_rate: assert property (p_osc_rate) else $error("oscillator tick too fast"); // RQ10
endmodule : amc_clkdiv
`default_nettype wire

// ### src/amc_if.sv
// Carrier between the top, the clock generator and the result memory.
// Assumes all members are driven and read on ref_clk_i.
`timescale 1ns/100ps
`default_nettype none
interface amc_if;
  logic [1:0]  div_sel;
  logic        use_audio;
  logic        ratio_sel;
  logic        pll_en;
  logic [5:0]  pll_k;
  logic [2:0]  pll_p;
  logic [3:0]  pll_q;
  logic        int_tick;
  logic        conv_tick;
  logic        we;
  logic [2:0]  waddr;
  logic [2:0]  raddr;
  logic [11:0] wdata;
  logic [11:0] rdata;
  modport clk_gen(input div_sel, use_audio, ratio_sel, pll_en, pll_k, pll_p, pll_q,
                  output int_tick, conv_tick);
  modport mem(input we, waddr, wdata, raddr, output rdata);
endinterface : amc_if
`default_nettype wire

// ### src/amc_pkg.sv
// Package for the auxiliary measurement converter control block.
// Assumes a 20 MHz reference clock and a SPI host that frames 32-bit words.
package amc_pkg;
  localparam int REF_CLK_KHZ = 20000;
  localparam int INT_CLK_KHZ = 8000;
  localparam int SAMPLE_TICKS = 3;

  localparam logic [6:0] ADDR_CTRL     = 7'h00;
  localparam logic [6:0] ADDR_REF      = 7'h01;
  localparam logic [6:0] ADDR_RATIO    = 7'h06;
  localparam logic [6:0] ADDR_RES_BASE = 7'h08;
  localparam logic [6:0] ADDR_RES_LAST = 7'h0C;

  localparam logic [2:0] CH_BAT   = 3'h0;
  localparam logic [2:0] CH_AUX1  = 3'h1;
  localparam logic [2:0] CH_AUX2  = 3'h2;
  localparam logic [2:0] CH_TEMP1 = 3'h3;
  localparam logic [2:0] CH_TEMP2 = 3'h4;

  localparam int CTRL_CH_LSB    = 0;
  localparam int CTRL_SCAN_BIT  = 3;
  localparam int CTRL_AVG_LSB   = 4;
  localparam int CTRL_RES_LSB   = 6;
  localparam int CTRL_DIV_LSB   = 8;
  localparam int CTRL_START_BIT = 15;
  localparam int REF_EN_BIT     = 0;
  localparam int REF_HI_BIT     = 1;
  localparam int RATIO_SEL_BIT  = 13;

  localparam logic [15:0] CTRL_RST  = 16'h0000;
  localparam logic [15:0] REF_RST   = 16'h0001;
  localparam logic [15:0] RATIO_RST = 16'h0000;

  localparam logic [1:0] RES_8  = 2'h1;
  localparam logic [1:0] RES_10 = 2'h2;

  localparam logic [5:0] SPI_CMD_LAST = 6'h07;
  localparam logic [5:0] SPI_HDR_LAST = 6'h0F;
  localparam logic [5:0] SPI_TX_FIRST = 6'h11;
  localparam logic [5:0] SPI_LAST     = 6'h1F;

  localparam logic [4:0] MULT_SEL0 = 5'h0D;
  localparam logic [4:0] MULT_SEL1 = 5'h11;
  localparam logic [7:0] PDIV_SEL0 = 8'hA0;
  localparam logic [7:0] PDIV_SEL1 = 8'hC0;
  localparam logic [7:0] QDIV_SEL0 = 8'h0A;

  typedef enum logic [4:0] {
    ST_IDLE  = 5'b00001,
    ST_SAMP  = 5'b00010,
    ST_CONV  = 5'b00100,
    ST_ACC   = 5'b01000,
    ST_STORE = 5'b10000
  } amc_state_t;
endpackage : amc_pkg

// ### src/amc_result_mem.sv
// Result store, one word per input channel, registered read port.
// Assumes write and read ports share ref_clk_i.
`timescale 1ns/100ps
`default_nettype none
module amc_result_mem #(
  parameter int DEPTH = 8
) (
  input  wire logic ref_clk_i,
  amc_if.mem        mif
);
  logic [11:0] mem_r [DEPTH];

  // No reset: results are undefined until first conversion
  always_ff @(posedge ref_clk_i) begin
    if (mif.we) begin
      mem_r[mif.waddr] <= mif.wdata;
    end
    mif.rdata <= mem_r[mif.raddr];
  end
endmodule : amc_result_mem
`default_nettype wire

// ### src/amc_top.sv
// Auxiliary measurement converter control with SPI register access.
// Assumes an analog SAR comparator latched on ref_clk_i and a mode 0 SPI host.
// Function
// RQ1 - One input multiplexer feeds a single SAR converter with built-in hold.
// RQ2 - Channel, scan, averaging, resolution and rate come from one control register.
// RQ3 - Each finished conversion lands in its own channel's result register.
// RQ4 - Results are unsigned binary, readable over the SPI port.
// RQ5 - Reference control selects internal level 1.25 V or 2.5 V.
// RQ6 - Internal reference can be switched off for an external reference.
// RQ7 - 8, 10 or 12 bit resolution; fewer bits take fewer cycles.
// RQ8 - Conversion clock is the 8 MHz internal clock divided by a register ratio.
// RQ9 - Host pairs 8 MHz with 8 bits, 4 MHz with 10, 1-2 MHz with 12.
// RQ10 - Internal clock stays 8 MHz; sampling costs fixed internal cycles.
// RQ11 - Oscillator runs only with audio paths off; else audio clocks drive it.
// RQ12 - Audio-derived clock ratio depends on PLL state and ratio select bit.
// RQ13 - PLL off, select 1: master times 17 over a parameterised divisor.
`timescale 1ns/100ps
`default_nettype none
module amc_top
  import amc_pkg::*;
#(
  parameter logic [7:0] DIRECT17_DIV = 8'h0A
) (
  input  wire logic        ref_clk_i,
  input  wire logic        nrst_i,
  input  wire logic        spi_sclk_i,
  input  wire logic        spi_ss_n_i,
  input  wire logic        spi_mosi_i,
  output logic             spi_miso_o,
  output logic             spi_miso_oe_o,
  input  wire logic        mclk_i,
  input  wire logic        audio_pwr_i,
  input  wire logic        pll_en_i,
  input  wire logic [5:0]  pll_k_i,
  input  wire logic [2:0]  pll_p_i,
  input  wire logic [3:0]  pll_q_i,
  input  wire logic        comp_i,
  output logic             osc_en_o,
  output logic             ref_en_o,
  output logic             ref_hi_o,
  output logic [2:0]       mux_sel_o,
  output logic             sample_o,
  output logic [11:0]      sar_code_o,
  output logic             busy_o
);
  amc_if bus();
  logic        sclk_s1, sclk_s2, sclk_s3, ss_s1, ss_s2, mosi_s1, mosi_s2;
  logic [5:0]  bit_cnt_r, bit_cnt_nxt;
  logic [15:0] rx_r, rx_nxt, tx_r, tx_nxt;
  logic [7:0]  cmd_r, cmd_nxt;
  logic        oe_r, oe_nxt;
  logic        sclk_rise, sclk_fall, reg_we;
  logic [15:0] rx_in, rd_data;
  logic [6:0]  reg_addr;
  logic [15:0] ctrl_r, ctrl_nxt, ref_r, ref_nxt, ratio_r, ratio_nxt;
  logic        osc_en_r;
  amc_state_t  state_r, state_nxt;
  logic [2:0]  ch_r, ch_nxt;
  logic [1:0]  samp_cnt_r, samp_cnt_nxt;
  logic [3:0]  bit_idx_r, bit_idx_nxt;
  logic [11:0] code_r, code_nxt;
  logic [15:0] sum_r, sum_nxt;
  logic [3:0]  avg_cnt_r, avg_cnt_nxt;
  logic [3:0]  nbits, avg_last;
  logic [1:0]  res_f, avg_f;
  logic        scan_f, done_clr;
  assign sclk_rise = sclk_s2 & ~sclk_s3;
  assign sclk_fall = ~sclk_s2 & sclk_s3;
  assign rx_in     = {rx_r[14:0], mosi_s2};
  assign reg_addr  = cmd_r[6:0];
  assign spi_miso_o    = tx_r[15];
  assign spi_miso_oe_o = oe_r;
  assign osc_en_o      = osc_en_r;
  assign ref_en_o      = ref_r[REF_EN_BIT]; // RQ6
  assign ref_hi_o      = ref_r[REF_HI_BIT]; // RQ5
  assign mux_sel_o     = ch_r; // RQ1
  assign sample_o      = state_r[1];
  assign sar_code_o    = code_r;
  assign busy_o        = ctrl_r[CTRL_START_BIT];
  assign bus.div_sel   = ctrl_r[CTRL_DIV_LSB +: 2]; // RQ8
  assign bus.use_audio = ~osc_en_r;
  assign bus.ratio_sel = ratio_r[RATIO_SEL_BIT]; // RQ12
  assign bus.pll_en    = pll_en_i;
  assign bus.pll_k     = pll_k_i;
  assign bus.pll_p     = pll_p_i;
  assign bus.pll_q     = pll_q_i;
  assign bus.raddr     = 3'(reg_addr - ADDR_RES_BASE);
  assign bus.we        = state_r[4]; // RQ3
  assign bus.waddr     = ch_r; // RQ3
  assign bus.wdata     = 12'(sum_r >> avg_f);
  amc_clkdiv #(
    .DIRECT17_DIV (DIRECT17_DIV)
  ) u_clkdiv (
    .ref_clk_i (ref_clk_i),
    .nrst_i    (nrst_i),
    .mclk_i    (mclk_i),
    .cif       (bus)
  );
  amc_result_mem #(
    .DEPTH (8)
  ) u_mem (
    .ref_clk_i (ref_clk_i),
    .mif       (bus)
  );
  // Register read mux; result words are zero-extended unsigned
  always_comb begin
    if (reg_addr == ADDR_CTRL) begin // RQ2
      rd_data = ctrl_r;
    end else if (reg_addr == ADDR_REF) begin
      rd_data = ref_r;
    end else if (reg_addr == ADDR_RATIO) begin
      rd_data = ratio_r;
    end else if (reg_addr >= ADDR_RES_BASE && reg_addr <= ADDR_RES_LAST) begin
      rd_data = {4'h0, bus.rdata}; // RQ4
    end else begin
      rd_data = 16'h0000;
    end
  end

  // SPI framing: command byte, pad byte, then 16 data bits
  always_comb begin
    bit_cnt_nxt = bit_cnt_r;
    rx_nxt      = rx_r;
    tx_nxt      = tx_r;
    cmd_nxt     = cmd_r;
    oe_nxt      = ~ss_s2;
    reg_we      = 1'b0;
    if (ss_s2) begin
      bit_cnt_nxt = 6'h00;
      tx_nxt      = 16'h0000;
    end else if (sclk_rise) begin
      rx_nxt      = rx_in;
      bit_cnt_nxt = bit_cnt_r + 6'h01;
      if (bit_cnt_r == SPI_CMD_LAST) begin
        cmd_nxt = rx_in[7:0];
      end
      if (bit_cnt_r == SPI_HDR_LAST && cmd_r[7]) begin
        tx_nxt = rd_data; // RQ4
      end
      if (bit_cnt_r == SPI_LAST && !cmd_r[7]) begin
        reg_we = 1'b1;
      end
    end else if (sclk_fall && bit_cnt_r >= SPI_TX_FIRST) begin
      tx_nxt = {tx_r[14:0], 1'b0};
    end
  end

  // Software start sets busy; hardware completion clears it, write wins
  always_comb begin
    ctrl_nxt  = ctrl_r;
    ref_nxt   = ref_r;
    ratio_nxt = ratio_r;
    if (done_clr) begin
      ctrl_nxt[CTRL_START_BIT] = 1'b0;
    end
    if (reg_we && reg_addr == ADDR_CTRL) begin // RQ2
      ctrl_nxt = rx_in;
    end
    if (reg_we && reg_addr == ADDR_REF) begin // RQ5 RQ6
      ref_nxt = {14'h0000, rx_in[1:0]};
    end
    if (reg_we && reg_addr == ADDR_RATIO) begin
      ratio_nxt = rx_in;
    end
  end

  always_comb begin
    res_f  = ctrl_r[CTRL_RES_LSB +: 2];
    avg_f  = ctrl_r[CTRL_AVG_LSB +: 2];
    scan_f = ctrl_r[CTRL_SCAN_BIT];
    if (res_f == RES_8) begin // RQ7
      nbits = 4'h8;
    end else if (res_f == RES_10) begin
      nbits = 4'hA;
    end else begin
      nbits = 4'hC;
    end
    avg_last     = 4'((5'h01 << avg_f) - 5'h01);
    state_nxt    = state_r;
    ch_nxt       = ch_r;
    samp_cnt_nxt = samp_cnt_r;
    bit_idx_nxt  = bit_idx_r;
    code_nxt     = code_r;
    sum_nxt      = sum_r;
    avg_cnt_nxt  = avg_cnt_r;
    done_clr     = 1'b0;
    case (state_r)
      ST_IDLE: begin
        if (ctrl_r[CTRL_START_BIT]) begin
          ch_nxt       = scan_f ? CH_BAT : ctrl_r[CTRL_CH_LSB +: 3]; // RQ1 RQ2
          state_nxt    = ST_SAMP;
          samp_cnt_nxt = 2'h0;
          sum_nxt      = 16'h0000;
          avg_cnt_nxt  = 4'h0;
        end
      end
      ST_SAMP: begin
        if (bus.int_tick) begin // RQ10
          if (samp_cnt_r == 2'(SAMPLE_TICKS - 1)) begin
            state_nxt   = ST_CONV;
            bit_idx_nxt = nbits - 4'h1;
            code_nxt    = 12'(13'h0001 << (nbits - 4'h1));
          end else begin
            samp_cnt_nxt = samp_cnt_r + 2'h1;
          end
        end
      end
      ST_CONV: begin
        if (bus.conv_tick) begin // RQ7
          if (!comp_i) begin
            code_nxt[bit_idx_r] = 1'b0;
          end
          if (bit_idx_r == 4'h0) begin
            state_nxt = ST_ACC;
          end else begin
            bit_idx_nxt = bit_idx_r - 4'h1;
            code_nxt[bit_idx_r - 4'h1] = 1'b1;
          end
        end
      end
      ST_ACC: begin
        sum_nxt     = sum_r + {4'h0, code_r};
        avg_cnt_nxt = avg_cnt_r + 4'h1;
        samp_cnt_nxt = 2'h0;
        state_nxt   = (avg_cnt_r == avg_last) ? ST_STORE : ST_SAMP;
      end
      ST_STORE: begin
        sum_nxt      = 16'h0000;
        avg_cnt_nxt  = 4'h0;
        samp_cnt_nxt = 2'h0;
        if (scan_f && ch_r != CH_AUX2) begin
          ch_nxt    = ch_r + 3'h1;
          state_nxt = ST_SAMP;
        end else begin
          done_clr  = 1'b1;
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sclk_s1    <= 1'b0;
      sclk_s2    <= 1'b0;
      sclk_s3    <= 1'b0;
      ss_s1      <= 1'b1;
      ss_s2      <= 1'b1;
      mosi_s1    <= 1'b0;
      mosi_s2    <= 1'b0;
      bit_cnt_r  <= 6'h00;
      rx_r       <= 16'h0000;
      tx_r       <= 16'h0000;
      cmd_r      <= 8'h00;
      oe_r       <= 1'b0;
      ctrl_r     <= CTRL_RST;
      ref_r      <= REF_RST;
      ratio_r    <= RATIO_RST;
      osc_en_r   <= 1'b1;
      state_r    <= ST_IDLE;
      ch_r       <= CH_BAT;
      samp_cnt_r <= 2'h0;
      bit_idx_r  <= 4'h0;
      code_r     <= 12'h000;
      sum_r      <= 16'h0000;
      avg_cnt_r  <= 4'h0;
    end else begin
      sclk_s1    <= spi_sclk_i;
      sclk_s2    <= sclk_s1;
      sclk_s3    <= sclk_s2;
      ss_s1      <= spi_ss_n_i;
      ss_s2      <= ss_s1;
      mosi_s1    <= spi_mosi_i;
      mosi_s2    <= mosi_s1;
      bit_cnt_r  <= bit_cnt_nxt;
      rx_r       <= rx_nxt;
      tx_r       <= tx_nxt;
      cmd_r      <= cmd_nxt;
      oe_r       <= oe_nxt;
      ctrl_r     <= ctrl_nxt;
      ref_r      <= ref_nxt;
      ratio_r    <= ratio_nxt;
      osc_en_r   <= ~audio_pwr_i; // RQ11
      state_r    <= state_nxt;
      ch_r       <= ch_nxt;
      samp_cnt_r <= samp_cnt_nxt;
      bit_idx_r  <= bit_idx_nxt;
      code_r     <= code_nxt;
      sum_r      <= sum_nxt;
      avg_cnt_r  <= avg_cnt_nxt;
    end
  end

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);
  property p_mux_held;
    (state_r inside {ST_SAMP, ST_CONV}) && $past(state_r inside {ST_SAMP, ST_CONV})
      |-> $stable(ch_r);
  endproperty
  a_mux_held: assert property (p_mux_held) else $error("mux moved mid conversion"); // RQ1
  property p_start;
    (state_r == ST_IDLE && ctrl_r[CTRL_START_BIT]) |=> state_r == ST_SAMP;
  endproperty
  a_start: assert property (p_start) else $error("start not taken"); // RQ2
  property p_store_chan;
    bus.we |-> bus.waddr == ch_r && $past(state_r) == ST_ACC;
  endproperty
  a_store_chan: assert property (p_store_chan) else $error("bad result channel"); // RQ3
  property p_unsigned;
    bus.we |-> (bus.wdata >> nbits) == 12'h000;
  endproperty
  a_unsigned: assert property (p_unsigned) else $error("result exceeds resolution"); // RQ4
  property p_ref_hi;
    (reg_we && reg_addr == ADDR_REF) |=> ref_hi_o == $past(rx_in[REF_HI_BIT]);
  endproperty
  a_ref_hi: assert property (p_ref_hi) else $error("reference level not taken"); // RQ5
  property p_ref_en;
    (reg_we && reg_addr == ADDR_REF) |=> ref_en_o == $past(rx_in[REF_EN_BIT]);
  endproperty
  a_ref_en: assert property (p_ref_en) else $error("reference enable not taken"); // RQ6
  property p_conv_len;
    (state_r == ST_SAMP) ##1 (state_r == ST_CONV) |-> bit_idx_r == nbits - 4'h1;
  endproperty
  a_conv_len: assert property (p_conv_len) else $error("wrong bit count"); // RQ7
  property p_samp_len;
    (state_r == ST_SAMP && bus.int_tick && samp_cnt_r == 2'(SAMPLE_TICKS - 1))
      |=> state_r == ST_CONV;
  endproperty
  a_samp_len: assert property (p_samp_len) else $error("sampling length wrong"); // RQ10
  property p_osc;
    audio_pwr_i |=> !osc_en_o;
  endproperty
  a_osc: assert property (p_osc) else $error("oscillator on with audio powered"); // RQ11
endmodule : amc_top
`default_nettype wire

// ### testbench/amc_spi_host.sv
// Host model: SPI mode 0, 32-bit frames, MSB first.
// Assumes ref_clk_i at 20 MHz; sclk half period of 5 ref cycles.
`timescale 1ns/100ps
`default_nettype none
module amc_spi_host (
  input  wire logic ref_clk_i,
  output logic      sclk_o,
  output logic      ss_n_o,
  output logic      mosi_o,
  input  wire logic miso_i
);
  initial begin
    sclk_o = 1'b0;
    ss_n_o = 1'b1;
    mosi_o = 1'b1;
  end

  // Read word is taken at rises 17 to 32
  task automatic xfer(input logic rd, input logic [6:0] a, input logic [15:0] wd,
                      output logic [15:0] rdat);
    logic [31:0] f;
    f = {rd, a, 8'h00, wd};
    rdat = 16'h0000;
    @(posedge ref_clk_i);
    ss_n_o <= 1'b0;
    for (int i = 31; i >= 0; i--) begin
      mosi_o <= f[i];
      repeat (5) @(posedge ref_clk_i);
      sclk_o <= 1'b1;
      if (i < 16) rdat = {rdat[14:0], miso_i};
      repeat (5) @(posedge ref_clk_i);
      sclk_o <= 1'b0;
    end
    repeat (5) @(posedge ref_clk_i);
    ss_n_o <= 1'b1;
    // Released line must not keep the last bit
    mosi_o <= ~f[0];
    repeat (8) @(posedge ref_clk_i);
  endtask : xfer
endmodule : amc_spi_host
`default_nettype wire

// ### testbench/tb_top.sv
// Self-checking bench for the measurement converter control block.
// Assumes the host model for SPI and a comparator that follows the trial code.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import amc_pkg::*;
  typedef struct packed {
    logic [15:0] ctl;
    logic [11:0] vin;
    logic [11:0] res;
  } amc_row_t;
  logic        ref_clk_i;
  logic        nrst_i;
  logic        sclk;
  logic        ss_n;
  logic        mosi;
  logic        miso;
  logic        miso_oe;
  logic        mclk_i;
  logic        audio_pwr_i;
  logic        pll_en_i;
  logic [5:0]  pll_k_i;
  logic [2:0]  pll_p_i;
  logic [3:0]  pll_q_i;
  logic        osc_en_o;
  logic        ref_en_o;
  logic        ref_hi_o;
  logic [2:0]  mux_sel_o;
  logic        sample_o;
  logic [11:0] sar_code_o;
  logic        busy_o;
  logic [11:0] vin;
  logic [3:0]  sh;
  logic [15:0] d;
  int          samp_cnt = 0;
  int          samp_len = 0;
  int          n_mismatch;
  int          compares;
  int          t [4];
  amc_row_t    rows [5];
  // Trial code scaled up to the 12-bit input for the resolution in use
  wire logic   comp_i = (vin >= (sar_code_o << sh));

  amc_top #(.DIRECT17_DIV(8'h0A)) i_amc_top (
    .ref_clk_i     (ref_clk_i),
    .nrst_i        (nrst_i),
    .spi_sclk_i    (sclk),
    .spi_ss_n_i    (ss_n),
    .spi_mosi_i    (mosi),
    .spi_miso_o    (miso),
    .spi_miso_oe_o (miso_oe),
    .mclk_i        (mclk_i),
    .audio_pwr_i   (audio_pwr_i),
    .pll_en_i      (pll_en_i),
    .pll_k_i       (pll_k_i),
    .pll_p_i       (pll_p_i),
    .pll_q_i       (pll_q_i),
    .comp_i        (comp_i),
    .osc_en_o      (osc_en_o),
    .ref_en_o      (ref_en_o),
    .ref_hi_o      (ref_hi_o),
    .mux_sel_o     (mux_sel_o),
    .sample_o      (sample_o),
    .sar_code_o    (sar_code_o),
    .busy_o        (busy_o)
  );

  amc_spi_host i_amc_spi_host (
    .ref_clk_i (ref_clk_i),
    .sclk_o    (sclk),
    .ss_n_o    (ss_n),
    .mosi_o    (mosi),
    .miso_i    (miso)
  );

  initial ref_clk_i = 1'b0;
  always #25 ref_clk_i = ~ref_clk_i;
  initial mclk_i = 1'b0;
  always #95 mclk_i = ~mclk_i;

  always @(posedge ref_clk_i) begin
    samp_cnt <= (sample_o === 1'b1) ? samp_cnt + 1 : 0;
    if (sample_o !== 1'b1 && samp_cnt != 0) samp_len <= samp_cnt;
  end

  task automatic finish_test();
    if (n_mismatch == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : finish_test

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [6:0] a, input logic [15:0] v);
    i_amc_spi_host.xfer(1'b0, a, v, d);
  endtask : wr

  task automatic rd(input logic [6:0] a, input logic [15:0] e);
    i_amc_spi_host.xfer(1'b1, a, 16'h0000, d);
    chk(d, e);
  endtask : rd

  // Start a run and wait, bounded, for busy to drop
  task automatic run(input logic [15:0] c, input logic [11:0] v, output int n);
    vin <= v;
    sh  <= (c[7:6] == RES_8) ? 4'h4 : (c[7:6] == RES_10) ? 4'h2 : 4'h0;
    wr(ADDR_CTRL, c);
    n = 0;
    while (busy_o !== 1'b0 && n < 20000) begin
      @(posedge ref_clk_i);
      n++;
    end
    chk({15'h0, busy_o}, 16'h0000);
  endtask : run

  initial begin
    n_mismatch = 0;
    compares = 0;
    vin = 12'h000;
    sh = 4'h0;
    nrst_i = 1'b0;
    audio_pwr_i = 1'b0;
    pll_en_i = 1'b0;
    pll_k_i = 6'h04;
    pll_p_i = 3'h1;
    pll_q_i = 4'h2;
    rows[0] = '{16'h8040, 12'hABC, 12'h0AB};
    rows[1] = '{16'h8191, 12'h3FF, 12'h0FF};
    rows[2] = '{16'h8222, 12'hFFF, 12'hFFF};
    rows[3] = '{16'h83F3, 12'h000, 12'h000};
    rows[4] = '{16'h8204, 12'h801, 12'h801};
    repeat (6) @(posedge ref_clk_i);
    nrst_i <= 1'b1;
    @(negedge ref_clk_i);
    chk({10'h0, osc_en_o, ref_en_o, ref_hi_o, busy_o, sample_o, miso_oe}, 16'h0030);
    rd(ADDR_REF, 16'h0001);
    rd(ADDR_RATIO, 16'h0000);
    foreach (rows[i]) begin
      run(rows[i].ctl, rows[i].vin, t[0]);
      chk({13'h0, mux_sel_o}, {13'h0, rows[i].ctl[2:0]});
      chk({15'h0, samp_len inside {[5:8]}}, 16'h0001);
      rd(ADDR_RES_BASE + {4'h0, rows[i].ctl[2:0]}, {4'h0, rows[i].res});
      rd(ADDR_CTRL, rows[i].ctl & 16'h7FFF);
    end
    // Same divider, fewer bits must finish sooner
    run(16'h8240, 12'h555, t[0]);
    run(16'h8200, 12'h555, t[1]);
    chk({15'h0, t[0] < t[1]}, 16'h0001);
    run(16'h8048, 12'h5A5, t[0]);
    for (int c = 0; c < 3; c++) rd(ADDR_RES_BASE + 7'(c), 16'h005A);
    rd(ADDR_RES_BASE + 7'h3, 16'h0000);
    rd(7'h05, 16'h0000);
    wr(ADDR_RES_BASE, 16'h0123);
    rd(ADDR_RES_BASE, 16'h005A);
    for (int v = 0; v < 4; v++) begin
      wr(ADDR_REF, 16'(v));
      chk({14'h0, ref_hi_o, ref_en_o}, 16'(v));
      rd(ADDR_REF, 16'(v));
    end
    audio_pwr_i <= 1'b1;
    repeat (2) @(posedge ref_clk_i);
    chk({15'h0, osc_en_o}, 16'h0000);
    for (int m = 0; m < 4; m++) begin
      pll_en_i <= m[1];
      wr(ADDR_RATIO, {2'h0, m[0], 13'h0000});
      run(16'h8041, 12'h7FF, t[m]);
      rd(ADDR_RES_BASE + 7'h1, 16'h007F);
    end
    chk({15'h0, t[0] > t[1]}, 16'h0001);
    chk({15'h0, t[2] > t[0] && t[2] > t[3]}, 16'h0001);
    audio_pwr_i <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
    chk({15'h0, osc_en_o}, 16'h0001);
    // Reset in mid-run must abort the run and restore defaults
    wr(ADDR_CTRL, 16'h83F3);
    repeat (20) @(posedge ref_clk_i);
    nrst_i <= 1'b0;
    repeat (6) @(posedge ref_clk_i);
    nrst_i <= 1'b1;
    @(negedge ref_clk_i);
    chk({10'h0, osc_en_o, ref_en_o, ref_hi_o, busy_o, sample_o, miso_oe}, 16'h0030);
    chk({1'h0, mux_sel_o, sar_code_o}, 16'h0000);
    rd(ADDR_CTRL, 16'h0000);
    rd(ADDR_REF, 16'h0001);
    finish_test();
  end

  initial begin
    repeat (90000) @(posedge ref_clk_i);
    n_mismatch++;
    finish_test();
  end
endmodule : tb_top
`default_nettype wire
